//--- core/sample_rate_reducer_replicator.sv
`timescale 1ns/1ns
// Summary of operation
// - Accept one converter word every sampling cycle
// - Averaging mode: average each group of N
// - Decimating mode: keep one of each N
// - Min/max mode: one pair per 2N inputs
// - Generator repeats each stored sample N cycles
// - Capture buffer 8k default, 16k alternate
// - Replay buffer 4k default, 16k alternate
// - Analog and digital acquisition share one clock
module sample_rate_reducer_replicator
  import rate_pkg::*;
#(
  parameter int CAPTURE_DEPTH = CAPTURE_DEPTH_DEFAULT,
  parameter int REPLAY_DEPTH  = REPLAY_DEPTH_DEFAULT,
  parameter int DIGITAL_W     = 16,
  parameter int CAP_AW        = $clog2(CAPTURE_DEPTH),
  parameter int REP_AW        = $clog2(REPLAY_DEPTH)
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  // Configuration, held steady while running
  input  wire logic [DIV_W-1:0]           rate_divider,
  input  wire reduce_mode_t               reduce_mode,
  input  wire logic                       capture_run,
  input  wire logic                       replay_run,
  // Converter and digital line inputs
  input  wire logic signed [SAMPLE_W-1:0] adc_sample,
  input  wire logic [DIGITAL_W-1:0]       digital_lines,
  // Capture buffer readout
  input  wire logic [CAP_AW-1:0]          capture_rd_addr,
  output logic [SAMPLE_W-1:0]             capture_rd_data,
  output logic [SAMPLE_W-1:0]             capture_rd_max,
  output logic [DIGITAL_W-1:0]            capture_rd_digital,
  output logic [CAP_AW:0]                 capture_count,
  output logic                            capture_full,
  // Replay buffer load port
  input  wire logic                       replay_wr_en,
  input  wire logic [REP_AW-1:0]          replay_wr_addr,
  input  wire logic [SAMPLE_W-1:0]        replay_wr_data,
  input  wire logic [REP_AW-1:0]          replay_length,
  // Output converter word
  output logic [SAMPLE_W-1:0]             dac_sample
);
  initial begin
    assert (CAPTURE_DEPTH <= CAPTURE_DEPTH_MAX && REPLAY_DEPTH <= REPLAY_DEPTH_MAX);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset release synchroniser
  logic rst_meta_n;  // First stage, read only by rst_sync_n
  logic rst_sync_n;  // Internal reset copy, active low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end
  wire rst_n_int = rst_sync_n;

  //////////////////////////////////////////////////////////////////////////////
  // Acquisition group counter
  // Divider of zero is treated as one so the path never stalls
  wire [DIV_W-1:0] div_n      = (rate_divider == '0) ? DIV_ONE : rate_divider;
  // Min/max groups span 2N inputs
  wire [DIV_W:0]   group_len  = (reduce_mode == MODE_MINMAX) ? {div_n, 1'b0} : {1'b0, div_n};
  logic [DIV_W:0]  grp_cnt;  // Position inside current group
  wire             grp_first  = (grp_cnt == '0);
  wire             grp_last   = (grp_cnt == group_len - 1'b1);
  wire             take       = capture_run && !capture_full;

  // Counter advances on every accepted word and clears while capture is stopped or full
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      grp_cnt <= '0;
    end else if (!take) begin
      grp_cnt <= '0;
    end else if (grp_last) begin
      grp_cnt <= '0;
    end else begin
      grp_cnt <= grp_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Averaging accumulator and min/max trackers
  logic signed [ACC_W-1:0]    acc;       // Full-width running sum
  logic signed [SAMPLE_W-1:0] run_min;   // Smallest so far in group
  logic signed [SAMPLE_W-1:0] run_max;   // Largest so far in group
  wire signed [ACC_W-1:0] sample_ext = ACC_W'(adc_sample);
  // Group restart drops the old sum instead of adding to it
  wire signed [ACC_W-1:0] next_acc   = grp_first ? sample_ext : acc + sample_ext;
  wire signed [SAMPLE_W-1:0] next_min = (grp_first || adc_sample < run_min) ? adc_sample : run_min;
  wire signed [SAMPLE_W-1:0] next_max = (grp_first || adc_sample > run_max) ? adc_sample : run_max;
  // Signed division truncates toward zero; a divider per lane costs area but keeps any N legal
  // Divider is far narrower than the sum, so its zero-extended copy is always positive
  wire signed [ACC_W-1:0] avg_full   = next_acc / $signed(ACC_W'(div_n));

  // Trackers update on every accepted word
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      acc     <= '0;
      run_min <= '0;
      run_max <= '0;
    end else if (take) begin
      acc     <= next_acc;
      run_min <= next_min;
      run_max <= next_max;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result selection, one store at the end of each group
  logic [SAMPLE_W-1:0] store_lo;
  logic [SAMPLE_W-1:0] store_hi;
  always_comb begin
    case (reduce_mode)
      MODE_AVERAGE: begin
        store_lo = avg_full[SAMPLE_W-1:0];
        store_hi = avg_full[SAMPLE_W-1:0];
      end
      MODE_DECIMATE: begin
        // Last word of the group is kept, the rest are discarded
        store_lo = adc_sample;
        store_hi = adc_sample;
      end
      MODE_MINMAX: begin
        store_lo = next_min;
        store_hi = next_max;
      end
      default: begin
        store_lo = adc_sample;
        store_hi = adc_sample;
      end
    endcase
  end
  wire store_en = take && grp_last;

  //////////////////////////////////////////////////////////////////////////////
  // Capture write pointer
  logic [CAP_AW:0] cap_ptr;  // Samples stored since capture start
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      cap_ptr <= '0;
    end else if (!capture_run) begin
      cap_ptr <= '0;
    end else if (store_en) begin
      cap_ptr <= cap_ptr + 1'b1;
    end
  end
  // Stops at depth so the oldest data is never overwritten
  assign capture_full  = (cap_ptr == (CAP_AW+1)'(CAPTURE_DEPTH));
  assign capture_count = cap_ptr;

  // Digital lines are stored on the edge that takes the group's last scope word;
  // a pipeline stage here would skew the two records by one sample
  wire [DIGITAL_W-1:0] dig_word = digital_lines;

  //////////////////////////////////////////////////////////////////////////////
  // Capture buffers: low word, high word, digital lines
  sample_memory #(.WIDTH(SAMPLE_W), .DEPTH(CAPTURE_DEPTH), .AW(CAP_AW)) u_cap_lo (
    .clk_sys (clk_sys),
    .wr_en   (store_en),
    .wr_addr (cap_ptr[CAP_AW-1:0]),
    .wr_data (store_lo),
    .rd_addr (capture_rd_addr),
    .rd_data (capture_rd_data)
  );
  sample_memory #(.WIDTH(SAMPLE_W), .DEPTH(CAPTURE_DEPTH), .AW(CAP_AW)) u_cap_hi (
    .clk_sys (clk_sys),
    .wr_en   (store_en),
    .wr_addr (cap_ptr[CAP_AW-1:0]),
    .wr_data (store_hi),
    .rd_addr (capture_rd_addr),
    .rd_data (capture_rd_max)
  );
  // Decimated in step with the analog path so both records align
  sample_memory #(.WIDTH(DIGITAL_W), .DEPTH(CAPTURE_DEPTH), .AW(CAP_AW)) u_cap_dig (
    .clk_sys (clk_sys),
    .wr_en   (store_en),
    .wr_addr (cap_ptr[CAP_AW-1:0]),
    .wr_data (dig_word),
    .rd_addr (capture_rd_addr),
    .rd_data (capture_rd_digital)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Replay sequencing
  logic [DIV_W-1:0]  rep_cnt;   // Repeat count of current sample
  logic [REP_AW-1:0] rep_addr;  // Stored sample being presented
  wire rep_last  = (rep_cnt == div_n - 1'b1);
  wire addr_last = (rep_addr == replay_length);

  // Address steps only after N cycles of the same word
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rep_cnt  <= '0;
      rep_addr <= '0;
    end else if (!replay_run) begin
      rep_cnt  <= '0;
      rep_addr <= '0;
    end else if (rep_last) begin
      rep_cnt  <= '0;
      rep_addr <= addr_last ? '0 : rep_addr + 1'b1;
    end else begin
      rep_cnt  <= rep_cnt + 1'b1;
    end
  end

  // Replay buffer; read latency is fixed so repeats stay N long
  logic [SAMPLE_W-1:0] rep_word;
  sample_memory #(.WIDTH(SAMPLE_W), .DEPTH(REPLAY_DEPTH), .AW(REP_AW)) u_rep (
    .clk_sys (clk_sys),
    .wr_en   (replay_wr_en),
    .wr_addr (replay_wr_addr),
    .wr_data (replay_wr_data),
    .rd_addr (rep_addr),
    .rd_data (rep_word)
  );

  // Converter word is driven every cycle, zero when idle
  logic rep_live;
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rep_live   <= 1'b0;
      dac_sample <= '0;
    end else begin
      rep_live   <= replay_run;
      dac_sample <= rep_live ? rep_word : '0;
    end
  end
endmodule

//--- core/rate_pkg.sv
package rate_pkg;
  // Converter word width (14-bit converters)
  localparam int SAMPLE_W        = 14;
  // Divider register width; N ranges 1 .. 2**DIV_W-1
  localparam int DIV_W           = 16;
  // Accumulator width: sample plus divider growth
  localparam int ACC_W           = SAMPLE_W + DIV_W;
  // Capture buffer depths in samples per channel
  localparam int CAPTURE_DEPTH_DEFAULT = 8192;
  localparam int CAPTURE_DEPTH_MAX     = 16384;
  // Replay buffer depths in samples per channel
  localparam int REPLAY_DEPTH_DEFAULT  = 4096;
  localparam int REPLAY_DEPTH_MAX      = 16384;
  // Sampling clock rate in Hz
  localparam int SAMPLE_RATE_HZ  = 100000000;
  // Smallest legal divider
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

  // Acquisition reduction modes
  typedef enum logic [1:0] {
    MODE_AVERAGE,
    MODE_DECIMATE,
    MODE_MINMAX
  } reduce_mode_t;
endpackage

//--- core/sample_memory.sv
`timescale 1ns/1ns
// Simple dual-port sample store, separate write and read addresses, with registered read data
module sample_memory #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8192,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_sys,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  // Storage array; no reset so it maps onto block RAM
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port, one cycle of latency
  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end
endmodule

//--- tb/rate_monitor.sv
`timescale 1ns/1ns
// Port-level checks on capture counting and replay pacing
module rate_monitor
  import rate_pkg::*;
#(
  parameter int CAPTURE_DEPTH = CAPTURE_DEPTH_DEFAULT,
  parameter int CAP_AW        = $clog2(CAPTURE_DEPTH)
) (
  input wire logic                clk_sys,
  input wire logic                reset_n,
  input wire logic [DIV_W-1:0]    rate_divider,
  input wire reduce_mode_t        reduce_mode,
  input wire logic                capture_run,
  input wire logic                replay_run,
  input wire logic [CAP_AW:0]     capture_count,
  input wire logic                capture_full,
  input wire logic [SAMPLE_W-1:0] dac_sample
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Count moved after a live capture cycle, so it was a store, not a clear
  sequence s_stored;
    $past(capture_run) && $changed(capture_count);
  endsequence
  // One word per group: every accepted word must be stored
  sequence s_single;
    capture_run && !capture_full && rate_divider <= DIV_ONE && reduce_mode != MODE_MINMAX;
  endsequence
  property p_full_level; capture_full == (capture_count == CAPTURE_DEPTH); endproperty
  property p_count_step; s_stored |-> capture_count == $past(capture_count) + 1; endproperty
  property p_every_cycle; s_single |=> capture_count == $past(capture_count) + 1; endproperty
  property p_minmax_pair;
    capture_run && reduce_mode == MODE_MINMAX && rate_divider == DIV_ONE ##0 s_stored |=> $stable(capture_count);
  endproperty
  property p_full_refuse; capture_full && capture_run |=> capture_full && $stable(capture_count); endproperty
  property p_stopped; !capture_run |=> capture_count <= $past(capture_count); endproperty
  // Three idle cycles cover the rep_live stage and the output register
  property p_dac_idle; (!replay_run)[*3] |-> dac_sample == '0; endproperty
  property p_dac_hold;
    replay_run && $past(replay_run) && rate_divider == 16'h0002 && $changed(dac_sample) |=> $stable(dac_sample);
  endproperty
  a_full_level: assert property (p_full_level) else $error("full flag disagrees with count");
  a_count_step: assert property (p_count_step) else $error("count moved by more than one");
  a_every_cycle: assert property (p_every_cycle) else $error("word not stored at divider one");
  a_minmax_pair: assert property (p_minmax_pair) else $error("pair stored on consecutive cycles");
  a_full_refuse: assert property (p_full_refuse) else $error("capture continued past full");
  a_stopped: assert property (p_stopped) else $error("count grew while stopped");
  a_dac_idle: assert property (p_dac_idle) else $error("output word not zero while idle");
  a_dac_hold: assert property (p_dac_hold) else $error("output word held under two cycles");
endmodule

bind sample_rate_reducer_replicator rate_monitor #(
  .CAPTURE_DEPTH(CAPTURE_DEPTH),
  .CAP_AW(CAP_AW)
) u_mon (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .rate_divider(rate_divider),
  .reduce_mode(reduce_mode),
  .capture_run(capture_run),
  .replay_run(replay_run),
  .capture_count(capture_count),
  .capture_full(capture_full),
  .dac_sample(dac_sample)
);

//--- tb/converter_model.sv
`timescale 1ns/1ns
// Input converter: an ideal quantiser with no aperture delay
module converter_model
  import rate_pkg::*;
(
  input  wire logic signed [SAMPLE_W-1:0] level,
  output logic signed      [SAMPLE_W-1:0] adc_sample
);
  // Code follows the level at once, so the bench knows each word taken
  assign adc_sample = level;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import rate_pkg::*;
;
  localparam int CD  = 16;
  localparam int CAW = $clog2(CD);
  logic                       clk_sys, reset_n, capture_run, replay_run, replay_wr_en, capture_full;
  logic [DIV_W-1:0]           rate_divider;
  reduce_mode_t               reduce_mode;
  logic signed [SAMPLE_W-1:0] level, adc_sample;
  logic [15:0]                digital_lines, capture_rd_digital;
  logic [15:0]                dig [$];
  logic [CAW-1:0]             capture_rd_addr, replay_wr_addr, replay_length;
  logic [SAMPLE_W-1:0]        capture_rd_data, capture_rd_max, replay_wr_data, dac_sample;
  logic [CAW:0]               capture_count;
  logic [31:0]                seed;
  logic [SAMPLE_W-1:0]        rep [4];
  int                         smp [$];
  int                         miscompares = 0;
  int                         compares = 0;
  ////////////////////////////////////////
  converter_model u_adc (.level(level), .adc_sample(adc_sample));
  sample_rate_reducer_replicator #(.CAPTURE_DEPTH(CD), .REPLAY_DEPTH(CD)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .rate_divider(rate_divider), .reduce_mode(reduce_mode),
    .capture_run(capture_run), .replay_run(replay_run), .adc_sample(adc_sample),
    .digital_lines(digital_lines), .capture_rd_addr(capture_rd_addr), .capture_rd_data(capture_rd_data),
    .capture_rd_max(capture_rd_max), .capture_rd_digital(capture_rd_digital), .capture_count(capture_count),
    .capture_full(capture_full), .replay_wr_en(replay_wr_en), .replay_wr_addr(replay_wr_addr),
    .replay_wr_data(replay_wr_data), .replay_length(replay_length), .dac_sample(dac_sample));
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected word of group g; hi picks the larger of a pair
  function automatic logic [SAMPLE_W-1:0] expect_word(reduce_mode_t m, int n, int g, bit hi);
    int gs, s, lo, up, v;
    gs = (m == MODE_MINMAX) ? 2 * n : n;
    s = 0;
    lo = 8191;
    up = -8192;
    for (int i = 0; i < gs; i++) begin
      v = smp[g * gs + i];
      s += v;
      lo = (v < lo) ? v : lo;
      up = (v > up) ? v : up;
    end
    if (m == MODE_MINMAX) return SAMPLE_W'(hi ? up : lo);
    // Integer division truncates toward zero, as the average must
    return SAMPLE_W'((m == MODE_AVERAGE) ? s / n : v);
  endfunction
  task automatic chk(string what, logic [31:0] want, logic [31:0] got);
    compares++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, want, got);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Feed whole groups, first group negative, then read back every word
  task automatic capture(reduce_mode_t m, int n, int groups);
    int gs;
    rate_divider = DIV_W'(n);
    // A divider of zero must behave as one
    n = (n == 0) ? 1 : n;
    gs = (m == MODE_MINMAX) ? 2 * n : n;
    smp.delete();
    dig.delete();
    reduce_mode = m;
    capture_run = 1'b1;
    for (int i = 0; i < groups * gs; i++) begin
      smp.push_back((i >= gs) ? int'($signed(rnd())) >>> 18 : (i == 0) ? -2 : -1);
      level = SAMPLE_W'(smp[i]);
      digital_lines = 16'(rnd());
      dig.push_back(digital_lines);
      @(posedge clk_sys);
      #1;
    end
    // A full buffer must refuse further words
    if (groups == CD) begin
      repeat (2) @(posedge clk_sys);
      #1;
    end
    chk("capture_count", groups, capture_count);
    chk("capture_full", groups == CD, capture_full);
    capture_run = 1'b0;
    for (int g = 0; g < groups; g++) begin
      capture_rd_addr = CAW'(g);
      @(posedge clk_sys);
      #1;
      chk("capture_rd_data", expect_word(m, n, g, 1'b0), capture_rd_data);
      chk("capture_rd_max", expect_word(m, n, g, 1'b1), capture_rd_max);
      // Digital record holds the lines seen with the group's last scope word
      chk("capture_rd_digital", dig[g * gs + gs - 1], capture_rd_digital);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Whole run is under two hundred cycles; this only cuts a hang short
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end
  initial begin
    seed = 32'h8FBA05AF;
    {reset_n, capture_run, replay_run, replay_wr_en} = 4'h0;
    rate_divider = DIV_ONE;
    reduce_mode = MODE_AVERAGE;
    level = '0;
    digital_lines = 16'h0000;
    capture_rd_addr = '0;
    replay_wr_addr = '0;
    replay_wr_data = '0;
    replay_length = CAW'(3);
    repeat (20) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    capture(MODE_AVERAGE, 3, 3);
    capture(MODE_AVERAGE, 1, 2);
    capture(MODE_AVERAGE, 0, 2);
    capture(MODE_DECIMATE, 3, 3);
    capture(MODE_MINMAX, 2, 3);
    capture(MODE_MINMAX, 1, 3);
    capture(MODE_DECIMATE, 1, CD);
    rate_divider = 16'h0002;
    for (int a = 0; a < 4; a++) begin
      rep[a] = SAMPLE_W'(rnd());
      replay_wr_en = 1'b1;
      replay_wr_addr = CAW'(a);
      replay_wr_data = rep[a];
      @(posedge clk_sys);
      #1;
    end
    replay_wr_en = 1'b0;
    replay_run = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    // Two laps show both the repeat count and the wrap
    for (int k = 0; k < 16; k++) begin
      chk("dac_sample", rep[(k / 2) % 4], dac_sample);
      @(posedge clk_sys);
      #1;
    end
    replay_run = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("dac_sample", 0, dac_sample);
    give_verdict();
  end
endmodule
